// File: design/bpr_cfg.svh
`ifndef BPR_CFG_SVH
`define BPR_CFG_SVH
// register byte addresses
`define BPR_ADDR_CTRL      6'h00
`define BPR_ADDR_STATUS    6'h04
`define BPR_ADDR_CFG       6'h08
// control/status bit positions
`define BPR_BIT_POR_FLAG   1
`define BPR_BIT_BOR_FLAG   0
`define BPR_BIT_SW_BOR_EN  6
`define BPR_BIT_SLEEP      8
// config field positions
`define BPR_CFG_MODE_LO    0
`define BPR_CFG_THR_LO     2
`define BPR_CFG_POWERUP_DELAY_COUNTER_N     4
`define BPR_CFG_PLL_EN     5
`define BPR_CFG_XTAL       6
// brown-out enable mode encodings
`define BPR_MODE_OFF       2'h0
`define BPR_MODE_SW        2'h1
`define BPR_MODE_NOSLEEP   2'h2
`define BPR_MODE_ALWAYS    2'h3
// timing: hclk 100 ns
`define BPR_CLK_NS         100
`define BPR_FILTER_NS      200
`define BPR_FILTER_CYC     ((`BPR_FILTER_NS + `BPR_CLK_NS - 1) / `BPR_CLK_NS)
`define BPR_POWERUP_DELAY_COUNTER_COUNT     2048
`define BPR_OST_COUNT      1024
`define BPR_PLL_MS         2
`define BPR_PLL_CYC        (`BPR_PLL_MS * 1000000 / `BPR_CLK_NS)
`endif

// File: design/bpr_pkg.sv
package bpr_pkg;
    typedef enum logic [4:0] {
        BPR_BROWNOUT = 5'h01,
        BPR_POWERUP_DELAY_COUNTER     = 5'h02,
        BPR_OST      = 5'h04,
        BPR_PLL      = 5'h08,
        BPR_RUN      = 5'h10
    } bpr_state_t;
endpackage : bpr_pkg

// File: design/bpr_reset_seq.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`include "bpr_cfg.svh"
module bpr_reset_seq
    import bpr_pkg::*;
#(
    parameter int PLL_CYCLES = `BPR_PLL_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        por_pulse,
    input  wire logic        supply_low,
    input  wire logic        internal_slow_rc_clock,
    input  wire logic        osc_clock,
    input  wire logic [7:0]  config_bits,
    output logic [1:0]       brownout_threshold_select,
    output logic             brownout_detect_on,
    output logic             device_reset
);
    localparam logic [10:0] POWERUP_DELAY_COUNTER_LAST = 11'(`BPR_POWERUP_DELAY_COUNTER_COUNT - 1);
    localparam logic [9:0]  OST_LAST  = 10'(`BPR_OST_COUNT - 1);
    localparam logic [21:0] PLL_LAST  = 22'(PLL_CYCLES - 1);
    localparam logic [3:0]  FILT_LAST = 4'(`BPR_FILTER_CYC - 1);

    function automatic logic detect_en(input logic [1:0] m, input logic sw,
                                       input logic slp);
        case (m)
            `BPR_MODE_SW:      detect_en = sw;
            `BPR_MODE_NOSLEEP: detect_en = !slp;
            `BPR_MODE_ALWAYS:  detect_en = 1'b1;
            default:           detect_en = 1'b0;
        endcase
    endfunction : detect_en

    logic [1:0] mode;
    logic       powerup_delay_counter_en;
    assign mode    = config_bits[`BPR_CFG_MODE_LO +: 2];
    assign powerup_delay_counter_en = !config_bits[`BPR_CFG_POWERUP_DELAY_COUNTER_N];

    // bus state
    logic        ph_wr, next_ph_wr, ph_rd, next_ph_rd;
    logic [5:0]  ph_addr, next_ph_addr;
    logic        sw_en, next_sw_en, sleep_req, next_sleep_req;
    logic        por_flag, next_por_flag, bor_flag, next_bor_flag;
    logic [31:0] next_hrdata;
    logic        next_hreadyout, next_hresp;
    // sequencer state
    bpr_state_t  state, next_state;
    logic [3:0]  filt, next_filt;
    logic [21:0] cnt, next_cnt;
    logic        rc_d, next_rc_d, osc_d, next_osc_d;
    logic        det, next_det, rst_out, next_rst_out;
    logic [1:0]  thr, next_thr;
    // holds checks off until the reset values have been shifted out
    logic        armed, next_armed;

    logic rc_rise, osc_rise, bor_event, brown_trip;
    assign rc_rise  = internal_slow_rc_clock && !rc_d;
    assign osc_rise = osc_clock && !osc_d;
    assign brown_trip = detect_en(mode, sw_en, sleep_req) && supply_low &&
                        filt == FILT_LAST;

    always_comb begin
        next_ph_wr   = 1'b0;
        next_ph_rd   = 1'b0;
        next_ph_addr = ph_addr;
        // zero-wait slave: every access finishes in one data phase
        next_hreadyout = 1'b1;
        next_hresp     = 1'b0;
        if (hready && hsel && htrans[1]) begin
            next_ph_wr   = hwrite;
            next_ph_rd   = !hwrite;
            next_ph_addr = haddr[5:0];
        end
        next_sw_en     = sw_en;
        next_sleep_req = sleep_req;
        next_por_flag  = por_flag;
        next_bor_flag  = bor_flag;
        if (ph_wr && ph_addr == `BPR_ADDR_CTRL) begin
            next_por_flag  = hwdata[`BPR_BIT_POR_FLAG];
            next_bor_flag  = hwdata[`BPR_BIT_BOR_FLAG];
            next_sw_en     = hwdata[`BPR_BIT_SW_BOR_EN];
            next_sleep_req = hwdata[`BPR_BIT_SLEEP];
        end
        if (brown_trip)
            next_bor_flag = 1'b0;
        if (por_pulse) begin
            next_por_flag = 1'b0;
            next_bor_flag = 1'b0;
            next_sw_en    = 1'b1;
        end
        next_hrdata = 32'h0;
        if (next_ph_rd) begin
            case (next_ph_addr)
                `BPR_ADDR_CTRL: begin
                    next_hrdata[`BPR_BIT_POR_FLAG]  = por_flag;
                    next_hrdata[`BPR_BIT_BOR_FLAG]  = bor_flag;
                    next_hrdata[`BPR_BIT_SW_BOR_EN] =
                        sw_en && mode == `BPR_MODE_SW;
                    next_hrdata[`BPR_BIT_SLEEP]     = sleep_req;
                end
                `BPR_ADDR_STATUS: next_hrdata = {25'h0, rst_out, det, state};
                `BPR_ADDR_CFG:    next_hrdata = {24'h0, config_bits};
                default:          next_hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr     <= 1'b0;
            ph_rd     <= 1'b0;
            ph_addr   <= 6'h00;
            sw_en     <= 1'b0;
            sleep_req <= 1'b0;
            por_flag  <= 1'b0;
            bor_flag  <= 1'b0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ph_wr     <= next_ph_wr;
            ph_rd     <= next_ph_rd;
            ph_addr   <= next_ph_addr;
            sw_en     <= next_sw_en;
            sleep_req <= next_sleep_req;
            por_flag  <= next_por_flag;
            bor_flag  <= next_bor_flag;
            hrdata    <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp     <= next_hresp;
        end
    end

    // sequencer: slow clocks are oversampled as plain inputs on hclk
    always_comb begin
        next_rc_d  = internal_slow_rc_clock;
        next_osc_d = osc_clock;
        next_thr   = config_bits[`BPR_CFG_THR_LO +: 2];
        next_armed = 1'b1;
        next_det   = detect_en(mode, sw_en, sleep_req);
        next_filt  = 4'h0;
        if (next_det && supply_low && filt != FILT_LAST)
            next_filt = filt + 4'h1;
        else if (next_det && supply_low)
            next_filt = filt;
        next_state = state;
        next_cnt   = cnt;
        case (state)
            BPR_BROWNOUT: begin
                next_cnt = 22'h0;
                if (!supply_low || !next_det)
                    next_state = powerup_delay_counter_en ? BPR_POWERUP_DELAY_COUNTER : BPR_OST;
            end
            BPR_POWERUP_DELAY_COUNTER: if (rc_rise) begin
                next_cnt = cnt + 22'h1;
                if (cnt[10:0] == POWERUP_DELAY_COUNTER_LAST) begin
                    next_cnt   = 22'h0;
                    next_state = BPR_OST;
                end
            end
            BPR_OST: begin
                if (!config_bits[`BPR_CFG_XTAL] &&
                    !config_bits[`BPR_CFG_PLL_EN])
                    next_state = BPR_RUN;
                else if (osc_rise) begin
                    next_cnt = cnt + 22'h1;
                    if (cnt[9:0] == OST_LAST) begin
                        next_cnt   = 22'h0;
                        next_state = config_bits[`BPR_CFG_PLL_EN] ?
                                     BPR_PLL : BPR_RUN;
                    end
                end
            end
            BPR_PLL: begin
                next_cnt = cnt + 22'h1;
                if (cnt == PLL_LAST)
                    next_state = BPR_RUN;
            end
            BPR_RUN:  next_state = BPR_RUN;
            default:  next_state = BPR_BROWNOUT;
        endcase
        if (brown_trip || por_pulse) begin
            next_state = BPR_BROWNOUT;
            next_cnt   = 22'h0;
        end
        next_rst_out = next_state != BPR_RUN;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= BPR_BROWNOUT;
            cnt     <= 22'h0;
            filt    <= 4'h0;
            rc_d    <= 1'b0;
            osc_d   <= 1'b0;
            det     <= 1'b0;
            rst_out <= 1'b1;
            thr     <= 2'h0;
            armed   <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            filt    <= next_filt;
            rc_d    <= next_rc_d;
            osc_d   <= next_osc_d;
            det     <= next_det;
            rst_out <= next_rst_out;
            thr     <= next_thr;
            armed   <= next_armed;
        end
    end
    assign device_reset              = rst_out;
    assign brownout_detect_on        = det;
    assign brownout_threshold_select = thr;

    // first cycle after reset still shows reset values: armed masks it
    por_clears_flag_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        por_pulse |=> !por_flag && !bor_flag)
        else $error("flags kept");
    bor_keeps_por_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        brown_trip && !por_pulse && !ph_wr |=> $stable(por_flag))
        else $error("por flag moved");
    por_only_sw_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        !por_flag ##1 por_flag |-> $past(ph_wr, 1))
        else $error("hw set");
    trip_resets_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        brown_trip |=> device_reset && state == BPR_BROWNOUT)
        else $error("no reset");
    dip_filter_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        supply_low && !$past(supply_low) |-> !brown_trip)
        else $error("dip tripped");
    hold_low_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state == BPR_BROWNOUT && supply_low && next_det
        |=> state == BPR_BROWNOUT) else $error("left early");
    powerup_delay_counter_next_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state == BPR_BROWNOUT && !supply_low && powerup_delay_counter_en && !por_pulse
        |=> state == BPR_POWERUP_DELAY_COUNTER) else $error("no delay");
    powerup_delay_counter_restart_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state == BPR_POWERUP_DELAY_COUNTER && brown_trip
        |=> state == BPR_BROWNOUT && cnt == 22'h0) else $error("no restart");
    powerup_delay_counter_skip_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state == BPR_BROWNOUT && !supply_low && !powerup_delay_counter_en && !por_pulse
        |=> state == BPR_OST) else $error("delay not skipped");
    sw_mode_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        mode == `BPR_MODE_SW |=> det == $past(sw_en))
        else $error("sw enable ignored");
    sleep_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        mode == `BPR_MODE_NOSLEEP |=> det == !$past(sleep_req))
        else $error("sleep gating wrong");
    always_on_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        mode == `BPR_MODE_ALWAYS |=> det) else $error("detect dropped");
    mode_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        mode == `BPR_MODE_OFF |=> !det && !brown_trip) else $error("off on");
    sw_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        ph_rd && ph_addr == `BPR_ADDR_CTRL && mode != `BPR_MODE_SW
        |-> !hrdata[`BPR_BIT_SW_BOR_EN]) else $error("sw bit seen");
    thr_cfg_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        1'b1 |=> brownout_threshold_select ==
                 $past(config_bits[`BPR_CFG_THR_LO +: 2]))
        else $error("threshold moved");
    powerup_delay_counter_width_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state == BPR_POWERUP_DELAY_COUNTER |-> cnt < 22'(`BPR_POWERUP_DELAY_COUNTER_COUNT))
        else $error("delay counter overrun");
    ost_skip_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state == BPR_OST && !config_bits[`BPR_CFG_XTAL] &&
        !config_bits[`BPR_CFG_PLL_EN] && !brown_trip && !por_pulse
        |=> state == BPR_RUN) else $error("start-up not skipped");
    pll_after_ost_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        $rose(state == BPR_PLL) |-> $past(state) == BPR_OST)
        else $error("lock delay out of order");
    trip_clears_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        brown_trip |=> !bor_flag) else $error("bor flag kept");
    reset_run_a: assert property (
        @(posedge hclk) disable iff (!hresetn || !armed)
        state != BPR_RUN |-> device_reset) else $error("early release");
endmodule : bpr_reset_seq

// File: testbench/bpr_supply_model.sv
module bpr_supply_model (
    input  wire logic hclk,
    input  wire logic low_req,
    output logic      supply_low,
    output logic      internal_slow_rc_clock,
    output logic      osc_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div = 2'h0;
    // both clocks move only after hclk edges: one rise every 4 cycles
    always @(posedge hclk) begin
        div <= div + 2'h1;
        supply_low <= low_req;
    end
    assign internal_slow_rc_clock = div[1];
    assign osc_clock = div[1];
endmodule : bpr_supply_model

// File: testbench/brownout_powerup_reset_control_test.sv
`include "bpr_cfg.svh"
module brownout_powerup_reset_control_test
    import bpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PL = 20;
    localparam int PUP = 2048 * 4 + 1024 * 4 + PL;
    localparam int OSP = 1024 * 4 + PL;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        por_pulse = 1'b0;
    logic        low_req = 1'b0;
    logic        supply_low;
    logic        rc;
    logic        osc;
    logic [7:0]  config_bits = 8'h6B;
    logic [1:0]  thr;
    logic        det;
    logic        dev_rst;
    logic [31:0] rd_val;
    int          n_fail = 0;
    int          checks = 0;

    bpr_reset_seq #(.PLL_CYCLES(PL)) bpr_reset_seq_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .por_pulse(por_pulse), .supply_low(supply_low),
        .internal_slow_rc_clock(rc), .osc_clock(osc),
        .config_bits(config_bits), .brownout_threshold_select(thr),
        .brownout_detect_on(det), .device_reset(dev_rst));

    bpr_supply_model bpr_supply_model_inst (
        .hclk(hclk), .low_req(low_req), .supply_low(supply_low),
        .internal_slow_rc_clock(rc), .osc_clock(osc));

    initial begin
        forever #50 hclk = ~hclk;
    end

    task automatic final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
        hsel <= 1'b0;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("hrdata", e, rd_val);
    endtask : rd

    // released cycles counted from the call; slow clocks add a little slack
    task automatic wait_rel(input int lo, input int hi);
        int n;
        n = 0;
        while (dev_rst !== 1'b0 && n < hi + 10) begin
            @(posedge hclk);
            n++;
        end
        checks++;
        if (n < lo || n > hi) begin
            n_fail++;
            $display("[ERR] release exp %0d..%0d got %0d", lo, hi, n);
        end
    endtask : wait_rel

    task automatic low_for(input int k);
        low_req <= 1'b1;
        repeat (k) @(posedge hclk);
        low_req <= 1'b0;
    endtask : low_for

    task automatic t_powerup;
        @(posedge hclk);
        por_pulse <= 1'b1;
        @(posedge hclk);
        por_pulse <= 1'b0;
        wait_rel(PUP - 8, PUP + 30);
        rd(`BPR_ADDR_CTRL, 32'h0);
        rd(`BPR_ADDR_STATUS, 32'h20 | 32'(BPR_RUN));
        chk("thr", 32'h2, {30'h0, thr});
        rd(`BPR_ADDR_CFG, 32'h6B);
        rd(6'h3C, 32'h0);
        bus(1'b1, `BPR_ADDR_STATUS, 32'h0);
        rd(`BPR_ADDR_STATUS, 32'h20 | 32'(BPR_RUN));
        bus(1'b1, `BPR_ADDR_CTRL, 32'h3);
        rd(`BPR_ADDR_CTRL, 32'h3);
    endtask : t_powerup

    task automatic t_trip;
        low_for(1);
        repeat (5) @(posedge hclk);
        chk("short dip", 32'h0, {31'h0, dev_rst});
        low_req <= 1'b1;
        repeat (5) @(posedge hclk);
        chk("trip", 32'h1, {31'h0, dev_rst});
        repeat (50) @(posedge hclk);
        chk("held", 32'h1, {31'h0, dev_rst});
        rd(`BPR_ADDR_CTRL, 32'h2);
        low_req <= 1'b0;
        repeat (4000) @(posedge hclk);
        chk("in delay", 32'h1, {31'h0, dev_rst});
        low_for(5);
        wait_rel(PUP - 8, PUP + 30);
        config_bits <= 8'h7B;
        low_for(5);
        wait_rel(OSP - 8, OSP + 30);
        config_bits <= 8'h1B;
        low_for(5);
        wait_rel(0, 30);
    endtask : t_trip

    task automatic t_modes;
        logic e;
        logic s_rd;
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
                for (int z = 0; z < 2; z++) begin
                    e = m == 3 || (m == 2 && z == 0) || (m == 1 && s == 1);
                    s_rd = m == 1 && s == 1;
                    config_bits <= 8'h18 | 8'(m);
                    bus(1'b1, `BPR_ADDR_CTRL, 32'h3 | 32'(s << 6 | z << 8));
                    repeat (3) @(posedge hclk);
                    chk("detect", 32'(e), {31'h0, det});
                    chk("thr", 32'h2, {30'h0, thr});
                    rd(`BPR_ADDR_CTRL, {23'h0, 1'(z), 1'b0, s_rd, 6'h3});
                    low_for(5);
                    chk("mode trip", 32'(e), {31'h0, dev_rst});
                    wait_rel(0, 40);
                end
    endtask : t_modes

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_powerup();
        t_trip();
        t_modes();
        final_report();
    end

    // whole run needs about 33000 cycles
    initial begin
        #(60000 * 100);
        n_fail++;
        final_report();
    end
endmodule : brownout_powerup_reset_control_test
